// [qps_device.sv]
// Serial slave front end of a quad digital potentiometer.
// Assumes a free-running sampling clock much faster than the serial clock.
`timescale 1ns/1ps
`include "qps_map.svh"
module qps_device
  import qps_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = `QPS_NV_WRITE_CYCLES,
  parameter logic [3:0] TYPE_ID = `QPS_TYPE_ID // Arbitrary value
) (
  input wire logic link_clk_in,
  input wire logic rst_in,
  qps_if.device bus,
  input wire logic [3:0] address_strap_in,
  output logic [`QPS_NUM_POTS*`QPS_TAPS-1:0] tap_select_out,
  output logic nv_busy_out
);
  localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);
  localparam int POS = `QPS_POS_W;
  if (NV_WRITE_CYCLES < 1) begin : g_bad_nv
    $error("NV_WRITE_CYCLES must be at least 1");
  end

  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_d_reg, sda_d_reg;
  logic [3:0] strap_meta_reg, strap_reg;
  qps_dev_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] shift_reg, cmd_reg, tx_reg;
  logic oe_reg, nv_pend_reg, nv_busy_reg;
  logic [NVW-1:0] nv_cnt_reg, nv_cnt_next;
  logic [POS-1:0] wcr_all [`QPS_NUM_POTS];
  logic [POS-1:0] dr_pick [`QPS_NUM_POTS];

  // Both lines sampled after two flops; edges come from the second stage on
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_end = (state_reg == QPS_D_RECV) & scl_fall & (bit_cnt_reg == `QPS_BYTE_BITS);
  wire type_ok = (shift_reg[7:4] == TYPE_ID);
  wire strap_ok = (shift_reg[3:0] == strap_reg);
  wire addr_match = type_ok & strap_ok & ~nv_busy_reg;
  wire [7:0] cur_cmd = (byte_idx_reg == 2'h1) ? shift_reg : cmd_reg;
  wire [3:0] op = cur_cmd[7:4];
  wire [1:0] psel = cur_cmd[3:2];
  wire [1:0] rsel = cur_cmd[1:0];
  wire cmd_acc = byte_end & (byte_idx_reg == 2'h1);
  wire data_acc = byte_end & (byte_idx_reg == 2'h2);
  wire op_read = (op == `QPS_OP_RD_WCR) | (op == `QPS_OP_RD_DR);
  wire op_write = (op == `QPS_OP_WR_WCR) | (op == `QPS_OP_WR_DR);
  wire nv_start = (cmd_acc & ((op == `QPS_OP_XFR_WCR_DR) | (op == `QPS_OP_G_WCR_DR)))
                  | (data_acc & (op == `QPS_OP_WR_DR));
  wire [7:0] rd_data = {2'h0, (op == `QPS_OP_RD_WCR) ? wcr_all[psel] : dr_pick[psel]};

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_meta_reg <= 4'h0;
      strap_reg <= 4'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      strap_meta_reg <= address_strap_in;
      strap_reg <= strap_meta_reg;
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= QPS_D_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      tx_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= QPS_D_RECV;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= QPS_D_IDLE;
      oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        QPS_D_RECV: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            if (byte_idx_reg == 2'h0 && !addr_match) begin
              state_reg <= QPS_D_IDLE;
            end else begin
              oe_reg <= 1'b1;
              state_reg <= QPS_D_ACK;
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
            if (cmd_acc) begin
              cmd_reg <= shift_reg;
            end
          end
        end
        QPS_D_ACK: if (scl_fall) begin
          bit_cnt_reg <= 4'h0;
          if (byte_idx_reg == 2'h2 && op_read) begin
            tx_reg <= rd_data;
            oe_reg <= ~rd_data[7];
            bit_cnt_reg <= 4'h1;
            state_reg <= QPS_D_SEND;
          end else begin
            oe_reg <= 1'b0;
            if (byte_idx_reg == 2'h1 || (byte_idx_reg == 2'h2 && op_write)) begin
              state_reg <= QPS_D_RECV;
            end else begin
              state_reg <= QPS_D_IDLE;
            end
          end
        end
        QPS_D_SEND: if (scl_fall) begin
          if (bit_cnt_reg == `QPS_BYTE_BITS) begin
            oe_reg <= 1'b0;
            state_reg <= QPS_D_MACK;
          end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            oe_reg <= ~tx_reg[6];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        // Only one byte is ever returned, so the master's answer just ends it
        QPS_D_MACK: if (scl_rise) begin
          state_reg <= QPS_D_IDLE;
        end
        QPS_D_IDLE: state_reg <= QPS_D_IDLE;
        default: state_reg <= QPS_D_IDLE;
      endcase
    end
  end

  // The write timer starts at the stop, as the master may still be talking before it
  always_comb begin
    nv_cnt_next = nv_cnt_reg;
    if (stop_det && nv_pend_reg) begin
      nv_cnt_next = NVW'(NV_WRITE_CYCLES);
    end else if (nv_cnt_reg != '0) begin
      nv_cnt_next = nv_cnt_reg - NVW'(1);
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nv_pend_reg <= 1'b0;
      nv_cnt_reg <= '0;
      nv_busy_reg <= 1'b0;
    end else begin
      nv_cnt_reg <= nv_cnt_next;
      nv_busy_reg <= (nv_cnt_next != '0);
      if (nv_start) begin
        nv_pend_reg <= 1'b1;
      end else if (stop_det) begin
        nv_pend_reg <= 1'b0;
      end
    end
  end

  for (genvar p = 0; p < `QPS_NUM_POTS; p++) begin : g_pot
    logic [POS-1:0] wcr_reg;
    logic [POS-1:0] dr_reg [`QPS_NUM_DR];
    wire hit = (psel == 2'(p));
    wire wcr_host = data_acc & hit & (op == `QPS_OP_WR_WCR);
    wire wcr_xfer = cmd_acc & ((hit & (op == `QPS_OP_XFR_DR_WCR)) | (op == `QPS_OP_G_DR_WCR));
    wire dr_host = data_acc & hit & (op == `QPS_OP_WR_DR);
    wire dr_xfer = cmd_acc & ((hit & (op == `QPS_OP_XFR_WCR_DR)) | (op == `QPS_OP_G_WCR_DR));
    always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
        wcr_reg <= '0;
        for (int r = 0; r < `QPS_NUM_DR; r++) begin
          dr_reg[r] <= '0;
        end
      end else begin
        if (wcr_host) begin
          wcr_reg <= shift_reg[POS-1:0];
        end else if (wcr_xfer) begin
          wcr_reg <= dr_reg[rsel];
        end
        if (dr_host) begin
          dr_reg[rsel] <= shift_reg[POS-1:0];
        end else if (dr_xfer) begin
          dr_reg[rsel] <= wcr_reg;
        end
      end
    end
    assign wcr_all[p] = wcr_reg;
    assign dr_pick[p] = dr_reg[rsel];
    qps_tap_decode u_tap (
      .clk_in(link_clk_in),
      .rst_in(rst_in),
      .position_in(wcr_reg),
      .tap_out(tap_select_out[p*`QPS_TAPS +: `QPS_TAPS])
    );
  end

  assign bus.sda_device_out = 1'b0;
  assign bus.sda_device_oe = oe_reg;
  assign nv_busy_out = nv_busy_reg;
endmodule : qps_device

// [qps_map.svh]
// Constants shared by both ends of the quad potentiometer serial link.
// Assumes nothing; definitions only.
`ifndef QPS_MAP_SVH
`define QPS_MAP_SVH
`define QPS_TYPE_ID 4'hb
`define QPS_NUM_POTS 4
`define QPS_NUM_DR 4
`define QPS_POS_W 6
`define QPS_TAPS 64
`define QPS_TAP_RESET 64'h0000000000000001
`define QPS_BYTE_BITS 4'h8
`define QPS_OP_RD_WCR 4'h9
`define QPS_OP_WR_WCR 4'ha
`define QPS_OP_RD_DR 4'hb
`define QPS_OP_WR_DR 4'hc
`define QPS_OP_XFR_DR_WCR 4'hd
`define QPS_OP_XFR_WCR_DR 4'he
`define QPS_OP_G_DR_WCR 4'h1
`define QPS_OP_G_WCR_DR 4'h8
`define QPS_LINK_CLK_NS 48
`define QPS_NV_WRITE_NS 5000000
`define QPS_NV_WRITE_CYCLES ((`QPS_NV_WRITE_NS + `QPS_LINK_CLK_NS - 1) / `QPS_LINK_CLK_NS)
`define QPS_CLK_NS 25
`define QPS_SCL_PERIOD_NS 10000
`define QPS_SCL_QUARTER_CYCLES (`QPS_SCL_PERIOD_NS / (4 * `QPS_CLK_NS))
`define QPS_REG_CMD 8'h00
`define QPS_REG_STAT 8'h04
`define QPS_CMD_GO 31
`define QPS_CMD_READ 25
`define QPS_CMD_THREE 24
`endif

// [qps_pkg.sv]
// Types shared by both ends of the quad potentiometer serial link.
// Assumes qps_map.svh for constants.
package qps_pkg;
  typedef enum logic [4:0] {
    QPS_D_IDLE = 5'h01,
    QPS_D_RECV = 5'h02,
    QPS_D_ACK = 5'h04,
    QPS_D_SEND = 5'h08,
    QPS_D_MACK = 5'h10
  } qps_dev_state_t;
  typedef enum logic [3:0] {
    QPS_M_IDLE = 4'h1,
    QPS_M_START = 4'h2,
    QPS_M_BITS = 4'h4,
    QPS_M_STOP = 4'h8
  } qps_mst_state_t;
endpackage : qps_pkg

// [qps_if.sv]
// Two-wire link between the controller and the potentiometer device.
// Assumes a pull-up: a line is high unless an enabled driver pulls it low.
`timescale 1ns/1ps
interface qps_if;
  logic scl;
  logic sda_master_out;
  logic sda_master_oe;
  logic sda_device_out;
  logic sda_device_oe;
  logic sda;
  assign sda = (sda_master_oe ? sda_master_out : 1'b1) & (sda_device_oe ? sda_device_out : 1'b1);
  modport master (output scl, output sda_master_out, output sda_master_oe, input sda);
  modport device (input scl, input sda, output sda_device_out, output sda_device_oe);
endinterface : qps_if

// [qps_tap_decode.sv]
// Registered one-hot tap switch select for one resistor array.
// Assumes the position comes from logic on the same clock.
`timescale 1ns/1ps
`include "qps_map.svh"
module qps_tap_decode
  import qps_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [`QPS_POS_W-1:0] position_in,
  output logic [`QPS_TAPS-1:0] tap_out
);
  logic [`QPS_TAPS-1:0] tap_next;
  // A shifted single one can never light two switches
  assign tap_next = `QPS_TAPS'(1) << position_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tap_out <= `QPS_TAP_RESET;
    end else begin
      tap_out <= tap_next;
    end
  end
endmodule : qps_tap_decode

// [qps_master.sv]
// Two-wire bus controller, driven by software over AHB-Lite.
// Assumes one AHB-Lite master, word transfers only, one device on the link.
`timescale 1ns/1ps
`include "qps_map.svh"
module qps_master
  import qps_pkg::*;
#(
  parameter int QUARTER_CYCLES = `QPS_SCL_QUARTER_CYCLES,
  parameter logic [3:0] TYPE_ID = `QPS_TYPE_ID // Arbitrary value
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  qps_if.master bus
);
  localparam int QW = $clog2(QUARTER_CYCLES + 1);
  if (QUARTER_CYCLES < 2) begin : g_bad_quarter
    $error("QUARTER_CYCLES must be at least 2");
  end
  qps_mst_state_t state_reg;
  logic [QW-1:0] q_cnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic [31:0] cmd_reg;
  logic [7:0] rx_reg, rdata_reg;
  logic scl_reg, oe_reg, nack_reg, wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [1:0] sda_sync_reg;
  wire addr_phase = hsel_in & htrans_in[1] & hready_in;
  wire [31:0] stat_word = {16'h0000, rdata_reg, 6'h00, nack_reg, state_reg != QPS_M_IDLE};
  wire [31:0] rd_mux = (haddr_in[7:0] == `QPS_REG_CMD) ? cmd_reg :
                       (haddr_in[7:0] == `QPS_REG_STAT) ? stat_word : 32'h00000000;
  wire launch = wr_pend_reg & (wr_addr_reg == `QPS_REG_CMD) & (state_reg == QPS_M_IDLE)
                & hwdata_in[`QPS_CMD_GO];
  wire tick = (q_cnt_reg == QW'(QUARTER_CYCLES - 1));
  wire sda_s = sda_sync_reg[1];
  wire last_byte = (byte_reg == (cmd_reg[`QPS_CMD_THREE] ? 2'h2 : 2'h1));
  wire rx_byte = cmd_reg[`QPS_CMD_READ] & (byte_reg == 2'h2);
  wire [7:0] cur_byte = (byte_reg == 2'h0) ? {TYPE_ID, cmd_reg[3:0]} :
                        (byte_reg == 2'h1) ? cmd_reg[15:8] : cmd_reg[23:16];
  // Pull low only for a zero bit; release after eight bits for the acknowledge
  wire drive_low = ~rx_byte & (bit_reg < `QPS_BYTE_BITS) & ~cur_byte[3'(4'h7 - bit_reg)];

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      sda_sync_reg <= 2'h3;
    end else begin
      wr_pend_reg <= addr_phase & hwrite_in;
      wr_addr_reg <= haddr_in[7:0];
      if (addr_phase & ~hwrite_in) begin
        hrdata_out <= rd_mux;
      end
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= QPS_M_IDLE;
      q_cnt_reg <= '0;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      byte_reg <= 2'h0;
      cmd_reg <= 32'h00000000;
      rx_reg <= 8'h00;
      rdata_reg <= 8'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      q_cnt_reg <= (state_reg == QPS_M_IDLE || tick) ? '0 : q_cnt_reg + QW'(1);
      if (state_reg != QPS_M_IDLE && tick) begin
        phase_reg <= phase_reg + 2'h1;
      end
      case (state_reg)
        QPS_M_IDLE: begin
          phase_reg <= 2'h0;
          if (launch) begin
            cmd_reg <= hwdata_in;
            nack_reg <= 1'b0;
            state_reg <= QPS_M_START;
          end
        end
        QPS_M_START: if (tick) begin
          if (phase_reg == 2'h0) begin
            oe_reg <= 1'b1;
          end else begin
            scl_reg <= 1'b0;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            byte_reg <= 2'h0;
            state_reg <= QPS_M_BITS;
          end
        end
        QPS_M_BITS: if (tick) begin
          case (phase_reg)
            2'h0: oe_reg <= drive_low;
            2'h1: scl_reg <= 1'b1;
            2'h2: if (bit_reg < `QPS_BYTE_BITS) begin
              rx_reg <= {rx_reg[6:0], sda_s};
            end else if (~rx_byte & sda_s) begin
              nack_reg <= 1'b1;
            end
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == `QPS_BYTE_BITS) begin
                bit_reg <= 4'h0;
                byte_reg <= byte_reg + 2'h1;
                if (nack_reg | last_byte) begin
                  state_reg <= QPS_M_STOP;
                end
              end
            end
          endcase
        end
        QPS_M_STOP: if (tick) begin
          case (phase_reg)
            2'h0: oe_reg <= 1'b1;
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_reg <= 1'b0;
            default: begin
              rdata_reg <= rx_reg;
              state_reg <= QPS_M_IDLE;
            end
          endcase
        end
        default: state_reg <= QPS_M_IDLE;
      endcase
    end
  end

  assign bus.scl = scl_reg;
  assign bus.sda_master_out = 1'b0;
  assign bus.sda_master_oe = oe_reg;
endmodule : qps_master

// [qps_link_properties.sv]
// Checker for the two-wire link between the controller and the potentiometer device.
// Assumes raw link lines plus the device's strap, tap and busy ports, link clock domain only.
`timescale 1ns/1ps
`include "qps_map.svh"
module qps_link_properties #(
  parameter logic [3:0] TYPE_ID = `QPS_TYPE_ID // Arbitrary value
) (
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_device_out,
  input wire logic sda_device_oe,
  input wire logic [3:0] address_strap_in,
  input wire logic [255:0] tap_select_out,
  input wire logic nv_busy_out
);
  logic scl_q, sda_q, in_frame, refused_reg, busy_seen_reg;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] shift_reg;
  wire start_det = scl_q && scl && sda_q && !sda;
  wire stop_det = scl_q && scl && !sda_q && sda;
  wire rise = in_frame && !scl_q && scl;
  wire ninth = rise && bit_cnt == 4'h8;
  wire first = ninth && byte_cnt == 2'h0;
  wire addr_ok = shift_reg == {TYPE_ID, address_strap_in};
  // Raw lines are watched; the device sees them later through its synchroniser
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      refused_reg <= 1'b0;
      busy_seen_reg <= 1'b0;
      bit_cnt <= 4'h0;
      byte_cnt <= 2'h0;
      shift_reg <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      busy_seen_reg <= nv_busy_out || (busy_seen_reg && !start_det);
      if (start_det) begin
        in_frame <= 1'b1;
        refused_reg <= 1'b0;
        bit_cnt <= 4'h0;
        byte_cnt <= 2'h0;
      end else if (stop_det) begin
        in_frame <= 1'b0;
      end else if (rise) begin
        bit_cnt <= ninth ? 4'h0 : bit_cnt + 4'h1;
        shift_reg <= ninth ? shift_reg : {shift_reg[6:0], sda};
        byte_cnt <= (ninth && byte_cnt != 2'h3) ? byte_cnt + 2'h1 : byte_cnt;
        refused_reg <= refused_reg || (first && !sda_device_oe);
      end
    end
  end
  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (rst_in);
  property p_scl_low;
    $changed(sda_device_oe) |-> !scl;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("data moved in clock high");
  property p_drain;
    sda_device_oe |-> !sda_device_out && !sda;
  endproperty
  a_drain: assert property (p_drain) else $error("data line not pulled low");
  property p_frame;
    !in_frame |-> !sda_device_oe;
  endproperty
  a_frame: assert property (p_frame) else $error("drive outside a frame");
  property p_ninth;
    rise && byte_cnt < 2'h2 && bit_cnt != 4'h8 |-> !sda_device_oe;
  endproperty
  a_ninth: assert property (p_ninth) else $error("drive off the ninth clock");
  property p_match;
    first && addr_ok && !busy_seen_reg && !nv_busy_out |-> sda_device_oe;
  endproperty
  a_match: assert property (p_match) else $error("address not acknowledged");
  property p_refuse;
    first && !addr_ok |-> !sda_device_oe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("foreign address acknowledged");
  property p_busy;
    first && nv_busy_out |-> !sda_device_oe;
  endproperty
  a_busy: assert property (p_busy) else $error("acknowledge while busy");
  property p_cmd;
    ninth && byte_cnt == 2'h1 && !refused_reg |-> sda_device_oe;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command not acknowledged");
  property p_quiet;
    refused_reg |-> !sda_device_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("drive after refusal");
  property p_onehot;
    $onehot(tap_select_out[63:0]) && $onehot(tap_select_out[127:64]) &&
      $onehot(tap_select_out[191:128]) && $onehot(tap_select_out[255:192]);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap select not one-hot");
endmodule : qps_link_properties

// [quad_pot_serial_slave_test.sv]
// Self-checking bench: controller and potentiometer device joined on one link.
// Assumes both ends keep their default type code; long counts shortened by parameter.
`timescale 1ns/1ps
`include "qps_map.svh"
module quad_pot_serial_slave_test;
  localparam int QC = 10;
  localparam int NVC = 400;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] wd;
    logic [1:0] kind;
    logic [7:0] rd;
    logic [23:0] pos;
  } qps_row_t;
  // Kind 0 two-byte, 1 write, 2 read; pos holds the four wiper values, pot 0 lowest
  qps_row_t rows [12] = '{
    '{8'ha0, 8'h3f, 2'h1, 8'h00, 24'h00003f}, '{8'h90, 8'h00, 2'h2, 8'h3f, 24'h00003f},
    '{8'ha8, 8'h15, 2'h1, 8'h00, 24'h01503f}, '{8'hc6, 8'h2a, 2'h1, 8'h00, 24'h01503f},
    '{8'hb6, 8'h00, 2'h2, 8'h2a, 24'h01503f}, '{8'hd6, 8'h00, 2'h0, 8'h00, 24'h015abf},
    '{8'he1, 8'h00, 2'h0, 8'h00, 24'h015abf}, '{8'hb1, 8'h00, 2'h2, 8'h3f, 24'h015abf},
    '{8'h20, 8'h00, 2'h0, 8'h00, 24'h015abf}, '{8'h11, 8'h00, 2'h0, 8'h00, 24'h00003f},
    '{8'h83, 8'h00, 2'h0, 8'h00, 24'h00003f}, '{8'hb3, 8'h00, 2'h2, 8'h3f, 24'h00003f}};
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] straps = 4'h5;
  logic [31:0] hrdata, stat;
  logic hready, hresp, nv_busy;
  logic [255:0] taps;
  int error_cnt = 0;
  int checks_done = 0;
  qps_if i_qps_if ();
  qps_master #(.QUARTER_CYCLES(QC)) i_qps_master (
    .clock_in(clk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .bus(i_qps_if.master));
  qps_device #(.NV_WRITE_CYCLES(NVC)) i_qps_device (
    .link_clk_in(link_clk), .rst_in(rst), .bus(i_qps_if.device),
    .address_strap_in(straps), .tap_select_out(taps), .nv_busy_out(nv_busy));
  qps_link_properties i_qps_link_properties (
    .link_clk_in(link_clk), .rst_in(rst), .scl(i_qps_if.scl), .sda(i_qps_if.sda),
    .sda_device_out(i_qps_if.sda_device_out), .sda_device_oe(i_qps_if.sda_device_oe),
    .address_strap_in(straps), .tap_select_out(taps), .nv_busy_out(nv_busy));
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_up();
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    finish_test();
  endtask : give_up
  // Zero wait states are promised, yet the master still waits on hready
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) give_up();
  endtask : ahb
  task automatic run_cmd(input logic [31:0] cmd, output logic [31:0] st);
    int n;
    ahb(32'h0, 1'b1, cmd, st);
    n = 0;
    do begin ahb(32'h4, 1'b0, 32'h0, st); n++; end while (st[0] !== 1'b0 && n < 5000);
    if (n >= 5000) give_up();
  endtask : run_cmd
  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) give_up();
  endtask : wait_idle
  function automatic logic [31:0] word(input logic [7:0] op, input logic [7:0] wd,
      input logic [1:0] kind, input logic [3:0] addr);
    return {1'b1, 5'h00, kind == 2'h2, kind != 2'h0, wd, op, 4'h0, addr};
  endfunction : word
  function automatic logic [255:0] taps_of(input logic [23:0] pos);
    logic [255:0] t;
    t = '0;
    for (int p = 0; p < 4; p++) t[p * 64 + pos[p * 6 +: 6]] = 1'b1;
    return t;
  endfunction : taps_of
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(taps, {4{`QPS_TAP_RESET}});
    check({i_qps_if.scl, i_qps_if.sda, nv_busy}, 3'h6);
    foreach (rows[i]) begin
      run_cmd(word(rows[i].op, rows[i].wd, rows[i].kind, 4'h5), stat);
      repeat (20) @(posedge clk);
      check(stat[1], 1'b0);
      if (rows[i].kind == 2'h2) check(stat[15:8], rows[i].rd);
      check(taps, taps_of(rows[i].pos));
      wait_idle();
    end
    // A store leaves the device deaf to its address until the write ends
    run_cmd(word(8'hc0, 8'h11, 2'h1, 4'h5), stat);
    run_cmd(word(8'hb0, 8'h00, 2'h2, 4'h5), stat);
    check(stat[1], 1'b1);
    wait_idle();
    run_cmd(word(8'hb0, 8'h00, 2'h2, 4'h5), stat);
    check({stat[15:8], stat[1]}, 9'h022);
    for (int b = 0; b < 4; b++) begin
      run_cmd(word(8'h90, 8'h00, 2'h2, 4'h5 ^ (4'h1 << b)), stat);
      check(stat[1], 1'b1);
    end
    straps <= 4'ha;
    repeat (4) @(posedge clk);
    run_cmd(word(8'h90, 8'h00, 2'h2, 4'ha), stat);
    check({stat[15:8], stat[1]}, 9'h07e);
    // Unmapped words read as zero and the bus never answers with an error
    ahb(32'h8, 1'b0, 32'h0, stat);
    check({hresp, stat}, 33'h000000000);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(taps, {4{`QPS_TAP_RESET}});
    check({i_qps_if.scl, i_qps_if.sda, nv_busy, hresp}, 4'hc);
    // Wipers return to zero and the link must work again after a mid-run reset
    run_cmd(word(8'h90, 8'h00, 2'h2, 4'ha), stat);
    check({stat[15:8], stat[1]}, 9'h000);
    finish_test();
  end
endmodule : quad_pot_serial_slave_test
